/* global_reset_gate_status_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module global_reset_gate_status_regs
  import clk_synth_global_pkg::*;
#(
  parameter int BIAS_TIMEOUT_CYCLES = BIAS_CAL_TIMEOUT_CYC,  // Bias calibration limit
  parameter int FUSE_TIMEOUT_CYCLES = FUSE_LOAD_TIMEOUT_CYC, // Fuse load limit
  parameter int APLL_TIMEOUT_CYCLES = APLL_LOCK_TIMEOUT_CYC, // Lock limit
  parameter int FALLBACK_CYCLES     = FALLBACK_WAIT_CYC      // Divider watch window
) (
  input  wire logic                    clk,                    // System clock
  input  wire logic                    sys_rst,                // Async reset, active high
  // Register port behind the serial interface
  input  wire logic [REG_IDX_W-1:0]    reg_index,              // Register index
  input  wire logic                    reg_wr,                 // Write strobe
  input  wire logic                    reg_rd,                 // Read strobe
  input  wire logic [REG_DATA_W-1:0]   reg_wdata,              // Write data
  output logic [REG_DATA_W-1:0]        reg_rdata,              // Read data
  output logic                         reg_rvalid,             // Read data valid pulse
  output logic                         reg_port_locked,        // Port frozen
  // Block reset holds
  output logic                         trim_logic_hold,        // Bias calibration reset
  output logic                         inv_input_activity_hold,     // Activity mon reset
  output logic                         true_input_activity_hold,    // Activity mon reset
  output logic                         crystal_signal_loss_hold,    // Loss mon reset
  output logic                         inv_input_signal_loss_hold,  // Loss mon reset
  output logic                         true_input_signal_loss_hold, // Loss mon reset
  output logic                         fuse_memory_logic_hold, // Fuse logic reset
  // Gated clocks
  output logic [NUM_MONITORS-1:0]      monitor_clk,            // Monitor clocks, bit 0 true loss
  output logic                         digital_clk,            // Remaining digital clock
  // Startup sequence handshakes
  input  wire logic                    bias_cal_done,          // Calibration finished
  output logic                         fuse_common_load_req,   // Load common config
  input  wire logic                    fuse_common_done,       // Common config loaded
  output logic                         fuse_user_load_req,     // Load user config
  input  wire logic [CONFIG_LOADED_W-1:0] user_config_sel,     // User config being loaded
  input  wire logic                    fuse_user_done,         // User config loaded
  input  wire logic                    apll_lock,              // Analog loop locked
  input  wire logic                    sys_div_toggle,         // System divider output
  output logic                         ring_osc_select         // Ring oscillator on sysclk
);

  logic [REG_DATA_W-1:0]      holds_q;
  logic [REG_DATA_W-1:0]      stops_q;
  logic [2:0]                 timeouts_q;
  logic                       fallback_q;
  logic                       ready_q;
  logic [CONFIG_LOADED_W-1:0] config_q;
  logic                       locked_q;
  logic [REG_DATA_W-1:0]      rdata_q;
  logic                       rvalid_q;
  startup_state_t             state_q;
  startup_state_t             state_d;
  logic                       step_done;
  logic                       step_timeout;
  logic                       div_prev_q;
  logic                       div_seen_q;
  logic [TIMER_W-1:0]         watch_q;
  logic [TIMER_W-1:0]         step_limit;
  logic                       entering;
  logic                       wr_ok;
  logic                       rd_ok;

  step_timer_if tmr_if ();

  // Merge write data into a register, keeping non-writable bits
  function automatic logic [REG_DATA_W-1:0] merge_write(
    input logic [REG_DATA_W-1:0] cur,
    input logic [REG_DATA_W-1:0] wdata,
    input logic [REG_DATA_W-1:0] wmask
  );
    merge_write = (cur & ~wmask) | (wdata & wmask);
  endfunction

  // Accesses count only while the port still has a clock
  assign wr_ok = reg_wr && !locked_q;
  assign rd_ok = reg_rd && !locked_q;

  // Block reset hold register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      holds_q <= BLOCK_RESET_HOLDS_RST;
    end else if (wr_ok && reg_index == IDX_BLOCK_RESET_HOLDS) begin
      holds_q <= merge_write(holds_q, reg_wdata, BLOCK_RESET_HOLDS_WMASK);
    end
  end

  // Clock stop register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stops_q <= BLOCK_CLOCK_STOPS_RST;
    end else if (wr_ok && reg_index == IDX_BLOCK_CLOCK_STOPS) begin
      stops_q <= merge_write(stops_q, reg_wdata, BLOCK_CLOCK_STOPS_WMASK);
    end
  end

  // Once the digital clock stops only a full reset revives the port
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      locked_q <= 1'b0;
    end else if (stops_q[DIGITAL_CLOCK_STOP_BIT]) begin
      locked_q <= 1'b1;
    end
  end

  // Read path; one cycle from strobe to data
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= rd_ok;
      if (rd_ok) begin
        case (reg_index)
          IDX_BLOCK_RESET_HOLDS: rdata_q <= holds_q;
          IDX_BLOCK_CLOCK_STOPS: rdata_q <= stops_q;
          IDX_STARTUP_STATUS: begin
            rdata_q <= '0;
            rdata_q[TIMEOUT_FIELD_LSB +: 3]                <= timeouts_q;
            rdata_q[OSC_FALLBACK_BIT]                      <= fallback_q;
            rdata_q[DEVICE_READY_BIT]                      <= ready_q;
            rdata_q[CONFIG_LOADED_LSB +: CONFIG_LOADED_W]  <= config_q;
          end
          default: rdata_q <= '0;
        endcase
      end
    end
  end

  assign reg_rdata       = rdata_q;
  assign reg_rvalid      = rvalid_q;
  assign reg_port_locked = locked_q;

  // Reset holds follow the register level, so clearing releases at once
  assign trim_logic_hold             = holds_q[TRIM_LOGIC_HOLD_BIT];
  assign inv_input_activity_hold     = holds_q[INV_INPUT_ACTIVITY_HOLD_BIT];
  assign true_input_activity_hold    = holds_q[TRUE_INPUT_ACTIVITY_HOLD_BIT];
  assign crystal_signal_loss_hold    = holds_q[CRYSTAL_SIGNAL_LOSS_HOLD_BIT];
  assign inv_input_signal_loss_hold  = holds_q[INV_INPUT_SIGNAL_LOSS_HOLD_BIT];
  assign true_input_signal_loss_hold = holds_q[TRUE_INPUT_SIGNAL_LOSS_HOLD_BIT];
  assign fuse_memory_logic_hold      = holds_q[FUSE_MEMORY_LOGIC_HOLD_BIT];

  // One glitch-free gate per monitor, bit i+1 stops monitor i
  for (genvar i = 0; i < NUM_MONITORS; i++) begin : g_mon_gate
    clock_stop_cell u_gate (
      .clk_in  (clk),
      .stop    (stops_q[MONITOR_STOP_LSB + i]),
      .clk_out (monitor_clk[i])
    );
  end

  // Everything without its own stop bit shares the digital gate
  clock_stop_cell u_dig_gate (
    .clk_in  (clk),
    .stop    (stops_q[DIGITAL_CLOCK_STOP_BIT]),
    .clk_out (digital_clk)
  );

  // Completion and limit for the current startup step
  always_comb begin
    step_done  = 1'b0;
    step_limit = '0;
    case (state_q)
      ST_BIAS_CAL: begin
        step_done  = bias_cal_done && !trim_logic_hold;
        step_limit = TIMER_W'(BIAS_TIMEOUT_CYCLES);
      end
      ST_FUSE_COMN: begin
        step_done  = fuse_common_done && !fuse_memory_logic_hold;
        step_limit = TIMER_W'(FUSE_TIMEOUT_CYCLES);
      end
      ST_FUSE_USER: begin
        step_done  = fuse_user_done && !fuse_memory_logic_hold;
        step_limit = TIMER_W'(FUSE_TIMEOUT_CYCLES);
      end
      ST_APLL_LOCK: begin
        step_done  = apll_lock;
        step_limit = TIMER_W'(APLL_TIMEOUT_CYCLES);
      end
      default: begin
        step_done  = 1'b0;
        step_limit = '0;
      end
    endcase
  end

  assign step_timeout = tmr_if.expired && !step_done && state_q != ST_RUN;

  // Sequence: bias, common config, user config, loop lock, run
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_BIAS_CAL:  if (step_done || step_timeout) state_d = ST_FUSE_COMN;
      ST_FUSE_COMN: begin
        if (step_done) state_d = ST_FUSE_USER;
        else if (step_timeout) state_d = ST_APLL_LOCK;
      end
      ST_FUSE_USER: if (step_done || step_timeout) state_d = ST_APLL_LOCK;
      ST_APLL_LOCK: if (step_done || step_timeout) state_d = ST_RUN;
      ST_RUN:       state_d = ST_RUN;
      default:      state_d = ST_BIAS_CAL;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_BIAS_CAL;
    end else begin
      state_q <= state_d;
    end
  end

  // The fuse timeout covers common and user loads together
  assign entering = (state_d != state_q) && (state_d != ST_FUSE_USER);

  // First cycle after reset also starts the bias step timer
  logic first_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  assign tmr_if.start = first_q || entering;
  assign tmr_if.limit = step_limit;

  step_timer u_step_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .tmr     (tmr_if.timer)
  );

  assign fuse_common_load_req = (state_q == ST_FUSE_COMN);
  assign fuse_user_load_req   = (state_q == ST_FUSE_USER);

  // Timeout flags are sticky until reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      timeouts_q <= STARTUP_STATUS_RST[TIMEOUT_FIELD_LSB +: 3];
    end else if (step_timeout) begin
      case (state_q)
        ST_BIAS_CAL:  timeouts_q[TIMEOUT_BIAS_OFS] <= 1'b1;
        ST_FUSE_COMN: timeouts_q[TIMEOUT_FUSE_OFS] <= 1'b1;
        ST_FUSE_USER: timeouts_q[TIMEOUT_FUSE_OFS] <= 1'b1;
        ST_APLL_LOCK: timeouts_q[TIMEOUT_APLL_OFS] <= 1'b1;
        default:      timeouts_q <= timeouts_q;
      endcase
    end
  end

  // Ready and loaded configuration latch when the user load finishes
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ready_q  <= STARTUP_STATUS_RST[DEVICE_READY_BIT];
      config_q <= STARTUP_STATUS_RST[CONFIG_LOADED_LSB +: CONFIG_LOADED_W];
    end else if (state_q == ST_FUSE_USER && step_done) begin
      ready_q  <= 1'b1;
      config_q <= user_config_sel;
    end
  end

  // Watch the divider; a silent window falls back to the ring oscillator
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_prev_q <= 1'b0;
      div_seen_q <= 1'b0;
      watch_q    <= '0;
      fallback_q <= 1'b0;
    end else begin
      div_prev_q <= sys_div_toggle;
      if (sys_div_toggle != div_prev_q) begin
        div_seen_q <= 1'b1;
      end
      if (!div_seen_q && !fallback_q) begin
        if (watch_q >= TIMER_W'(FALLBACK_CYCLES - 1)) begin
          fallback_q <= 1'b1;
        end else begin
          watch_q <= watch_q + 1'b1;
        end
      end
    end
  end

  assign ring_osc_select = fallback_q;

endmodule
`default_nettype wire

/* clk_synth_global_pkg.sv */
package clk_synth_global_pkg;

  // Register data and index widths
  localparam int REG_DATA_W = 16;
  localparam int REG_IDX_W  = 2;

  // Register indices on the internal register port
  localparam logic [REG_IDX_W-1:0] IDX_BLOCK_RESET_HOLDS = 2'h0;
  localparam logic [REG_IDX_W-1:0] IDX_BLOCK_CLOCK_STOPS = 2'h1;
  localparam logic [REG_IDX_W-1:0] IDX_STARTUP_STATUS    = 2'h2;

  // Reset values
  localparam logic [15:0] BLOCK_RESET_HOLDS_RST = 16'h0000;
  localparam logic [15:0] BLOCK_CLOCK_STOPS_RST = 16'h0000;
  localparam logic [7:0]  STARTUP_STATUS_RST    = 8'h00;

  // Writable bits; reserved RW bits store, reserved RO bits do not
  localparam logic [15:0] BLOCK_RESET_HOLDS_WMASK = 16'h093f;
  localparam logic [15:0] BLOCK_CLOCK_STOPS_WMASK = 16'h097f;

  // Block reset hold field positions
  localparam int TRIM_LOGIC_HOLD_BIT             = 8;
  localparam int INV_INPUT_ACTIVITY_HOLD_BIT     = 5;
  localparam int TRUE_INPUT_ACTIVITY_HOLD_BIT    = 4;
  localparam int CRYSTAL_SIGNAL_LOSS_HOLD_BIT    = 3;
  localparam int INV_INPUT_SIGNAL_LOSS_HOLD_BIT  = 2;
  localparam int TRUE_INPUT_SIGNAL_LOSS_HOLD_BIT = 1;
  localparam int FUSE_MEMORY_LOGIC_HOLD_BIT      = 0;

  // Clock stop field positions; monitor stops occupy bits 5..1
  localparam int DIGITAL_CLOCK_STOP_BIT = 11;
  localparam int MONITOR_STOP_LSB       = 1;
  localparam int NUM_MONITORS           = 5;

  // Startup status field positions
  localparam int TIMEOUT_FIELD_LSB   = 5;
  localparam int TIMEOUT_BIAS_OFS    = 0;
  localparam int TIMEOUT_FUSE_OFS    = 1;
  localparam int TIMEOUT_APLL_OFS    = 2;
  localparam int OSC_FALLBACK_BIT    = 4;
  localparam int DEVICE_READY_BIT    = 3;
  localparam int CONFIG_LOADED_LSB   = 0;
  localparam int CONFIG_LOADED_W     = 2;

  // Timing
  localparam int CLK_FREQ_HZ            = 200_000_000;
  localparam int BIAS_CAL_TIMEOUT_MS    = 2;
  localparam int FUSE_LOAD_TIMEOUT_MS   = 10;
  localparam int APLL_LOCK_TIMEOUT_MS   = 2;
  localparam int BIAS_CAL_TIMEOUT_CYC   = BIAS_CAL_TIMEOUT_MS * (CLK_FREQ_HZ / 1000);
  localparam int FUSE_LOAD_TIMEOUT_CYC  = FUSE_LOAD_TIMEOUT_MS * (CLK_FREQ_HZ / 1000);
  localparam int APLL_LOCK_TIMEOUT_CYC  = APLL_LOCK_TIMEOUT_MS * (CLK_FREQ_HZ / 1000);
  localparam int FALLBACK_WAIT_CYC      = 64;
  localparam int TIMER_W                = 22;

  // Startup sequence states
  typedef enum logic [2:0] {
    ST_BIAS_CAL  = 3'b000,
    ST_FUSE_COMN = 3'b001,
    ST_FUSE_USER = 3'b010,
    ST_APLL_LOCK = 3'b011,
    ST_RUN       = 3'b100
  } startup_state_t;

endpackage

/* step_timer_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface step_timer_if;
  import clk_synth_global_pkg::*;
  logic               start;   // Restart count from zero
  logic [TIMER_W-1:0] limit;   // Cycles until expiry
  logic               expired; // Limit reached, level until next start

  modport owner (output start, output limit, input expired);
  modport timer (input start, input limit, output expired);
endinterface
`default_nettype wire

/* step_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module step_timer
  import clk_synth_global_pkg::*;
(
  input  wire logic   clk,     // System clock
  input  wire logic   sys_rst, // Async reset, active high
  step_timer_if.timer tmr      // Start, limit and expiry
);

  logic [TIMER_W-1:0] count_q;
  logic               expired_q;

  // Count up after start; saturate once the limit is met
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_q   <= '0;
      expired_q <= 1'b0;
    end else if (tmr.start) begin
      count_q   <= '0;
      expired_q <= 1'b0;
    end else if (!expired_q) begin
      count_q   <= count_q + 1'b1;
      expired_q <= (count_q + 1'b1) >= tmr.limit;
    end
  end

  assign tmr.expired = expired_q;

endmodule
`default_nettype wire

/* clock_stop_cell.sv */
`timescale 1ns/1ps
`default_nettype none
module clock_stop_cell (
  input  wire logic clk_in,  // Free-running clock
  input  wire logic stop,    // High stops the clock
  output logic      clk_out  // Gated clock
);

  logic enable_l;

  // Enable latched while the clock is low so the output never glitches
  always_latch begin
    if (!clk_in) begin
      enable_l <= ~stop;
    end
  end

  assign clk_out = clk_in & enable_l;

endmodule
`default_nettype wire

/* global_regs_props.sv */
`timescale 1ns/1ps
`default_nettype none
module global_regs_props
  import clk_synth_global_pkg::*;
(
  input wire logic                  clk,                         // System clock
  input wire logic                  sys_rst,                     // Async reset
  input wire logic [REG_IDX_W-1:0]  reg_index,                   // Register index
  input wire logic                  reg_wr,                      // Write strobe
  input wire logic                  reg_rd,                      // Read strobe
  input wire logic [REG_DATA_W-1:0] reg_wdata,                   // Write data
  input wire logic [REG_DATA_W-1:0] reg_rdata,                   // Read data
  input wire logic                  reg_rvalid,                  // Read valid
  input wire logic                  reg_port_locked,             // Port frozen
  input wire logic                  trim_logic_hold,             // Bias hold
  input wire logic                  inv_input_activity_hold,     // Activity hold
  input wire logic                  true_input_activity_hold,    // Activity hold
  input wire logic                  crystal_signal_loss_hold,    // Loss hold
  input wire logic                  inv_input_signal_loss_hold,  // Loss hold
  input wire logic                  true_input_signal_loss_hold, // Loss hold
  input wire logic                  fuse_memory_logic_hold,      // Fuse hold
  input wire logic [NUM_MONITORS-1:0] monitor_clk,               // Monitor clocks
  input wire logic                  digital_clk                  // Digital clock
);
  logic        wr_hold;
  logic        wr_stop;
  logic [15:0] stop_q;
  logic [15:0] stop_seen_q;

  default disable iff (sys_rst);

  // Accepted writes as the port sees them
  assign wr_hold = reg_wr && !reg_port_locked && reg_index == IDX_BLOCK_RESET_HOLDS;
  assign wr_stop = reg_wr && !reg_port_locked && reg_index == IDX_BLOCK_CLOCK_STOPS;

  // Stop shadow; second stage because the gate latch opens only in the low phase
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stop_q      <= 16'h0000;
      stop_seen_q <= 16'h0000;
    end else begin
      if (wr_stop)
        stop_q <= reg_wdata & BLOCK_CLOCK_STOPS_WMASK;
      stop_seen_q <= stop_q;
    end
  end

  sequence s_stop_digital;
    wr_stop && reg_wdata[DIGITAL_CLOCK_STOP_BIT];
  endsequence
  sequence s_status_read;
    reg_rd && !reg_port_locked && reg_index == IDX_STARTUP_STATUS;
  endsequence

  a_trim_hold_write: assert property (@(posedge clk) wr_hold |=>
    trim_logic_hold == $past(reg_wdata[8])) else $error("trim hold wrong");
  a_activity_hold_write: assert property (@(posedge clk) wr_hold |=>
    {inv_input_activity_hold, true_input_activity_hold} == $past(reg_wdata[5:4]))
    else $error("activity hold wrong");
  a_loss_hold_write: assert property (@(posedge clk) wr_hold |=> {crystal_signal_loss_hold,
    inv_input_signal_loss_hold, true_input_signal_loss_hold} == $past(reg_wdata[3:1]))
    else $error("loss hold wrong");
  a_fuse_hold_write: assert property (@(posedge clk) wr_hold |=>
    fuse_memory_logic_hold == $past(reg_wdata[0])) else $error("fuse hold wrong");
  a_monitor_clk_gate: assert property (@(negedge clk)
    monitor_clk == ~stop_seen_q[5:1]) else $error("monitor clock gating wrong");
  a_digital_clk_gate: assert property (@(negedge clk)
    digital_clk == !stop_seen_q[11]) else $error("digital clock gating wrong");
  a_lock_after_stop: assert property (@(posedge clk) s_stop_digital |->
    ##[1:2] reg_port_locked[*4]) else $error("port not locked");
  a_locked_no_answer: assert property (@(posedge clk) reg_port_locked |=>
    reg_port_locked && !reg_rvalid) else $error("locked port answered");
  a_read_answer: assert property (@(posedge clk) reg_rd && !reg_port_locked |=>
    reg_rvalid) else $error("read not answered");
  a_status_reserved: assert property (@(posedge clk) s_status_read |=>
    reg_rdata[15:8] == 8'h00 && !reg_rdata[2]) else $error("reserved status bits set");
endmodule

bind global_reset_gate_status_regs global_regs_props u_props (
  .clk(clk), .sys_rst(sys_rst), .reg_index(reg_index), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .reg_port_locked(reg_port_locked), .trim_logic_hold(trim_logic_hold),
  .inv_input_activity_hold(inv_input_activity_hold),
  .true_input_activity_hold(true_input_activity_hold),
  .crystal_signal_loss_hold(crystal_signal_loss_hold),
  .inv_input_signal_loss_hold(inv_input_signal_loss_hold),
  .true_input_signal_loss_hold(true_input_signal_loss_hold),
  .fuse_memory_logic_hold(fuse_memory_logic_hold), .monitor_clk(monitor_clk),
  .digital_clk(digital_clk));
`default_nettype wire

/* startup_responder.sv */
`timescale 1ns/1ps
`default_nettype none
module startup_responder #(
  parameter logic [1:0] CFG = 2'h2 // User configuration offered
) (
  input  wire logic clk,                  // System clock
  input  wire logic sys_rst,              // Async reset
  input  wire logic quiet,                // Never answer, divider stuck
  input  wire logic fuse_common_load_req, // Common load asked
  input  wire logic fuse_user_load_req,   // User load asked
  output logic       bias_cal_done,        // Calibration done
  output logic       fuse_common_done,     // Common loaded
  output logic       fuse_user_done,       // User loaded
  output logic [1:0] user_config_sel,      // Config being loaded
  output logic       apll_lock,            // Loop locked
  output logic       sys_div_toggle        // Divider output
);
  logic [2:0] creq_q;
  logic [2:0] ureq_q;
  logic       user_seen_q;

  // Loads take three cycles, so the design must wait rather than assume
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      creq_q         <= 3'h0;
      ureq_q         <= 3'h0;
      user_seen_q    <= 1'b0;
      sys_div_toggle <= 1'b0;
    end else begin
      creq_q         <= {creq_q[1:0], fuse_common_load_req};
      ureq_q         <= {ureq_q[1:0], fuse_user_load_req};
      user_seen_q    <= user_seen_q | fuse_user_done;
      sys_div_toggle <= quiet ? sys_div_toggle : ~sys_div_toggle;
    end
  end

  assign bias_cal_done    = !quiet;
  assign fuse_common_done = !quiet && creq_q[2];
  assign fuse_user_done   = !quiet && ureq_q[2];
  // Select shows the inverse outside the load so a late capture is caught
  assign user_config_sel  = fuse_user_load_req ? CFG : ~CFG;
  assign apll_lock        = !quiet && user_seen_q;
endmodule
`default_nettype wire

/* global_reset_gate_status_regs_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module global_reset_gate_status_regs_tb_top;
  import clk_synth_global_pkg::*;
  logic        clk, sys_rst, reg_wr, reg_rd, quiet, reg_rvalid, reg_port_locked, digital_clk;
  logic [1:0]  reg_index, user_config_sel;
  logic [15:0] reg_wdata, reg_rdata;
  logic [6:0]  holds;
  logic [4:0]  monitor_clk;
  logic        bias_done, com_req, com_done, usr_req, usr_done, lock, div_tog, ring_osc;
  int          miscompares, tests_run, cycles;

  global_reset_gate_status_regs #(.BIAS_TIMEOUT_CYCLES(20), .FUSE_TIMEOUT_CYCLES(50),
    .APLL_TIMEOUT_CYCLES(20), .FALLBACK_CYCLES(8)) u_dut (
    .clk(clk), .sys_rst(sys_rst), .reg_index(reg_index), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_port_locked(reg_port_locked), .trim_logic_hold(holds[6]),
    .inv_input_activity_hold(holds[5]), .true_input_activity_hold(holds[4]),
    .crystal_signal_loss_hold(holds[3]), .inv_input_signal_loss_hold(holds[2]),
    .true_input_signal_loss_hold(holds[1]), .fuse_memory_logic_hold(holds[0]),
    .monitor_clk(monitor_clk), .digital_clk(digital_clk), .bias_cal_done(bias_done),
    .fuse_common_load_req(com_req), .fuse_common_done(com_done),
    .fuse_user_load_req(usr_req), .user_config_sel(user_config_sel),
    .fuse_user_done(usr_done), .apll_lock(lock), .sys_div_toggle(div_tog),
    .ring_osc_select(ring_osc));

  startup_responder u_resp (.clk(clk), .sys_rst(sys_rst), .quiet(quiet),
    .fuse_common_load_req(com_req), .fuse_user_load_req(usr_req),
    .bias_cal_done(bias_done), .fuse_common_done(com_done), .fuse_user_done(usr_done),
    .user_config_sel(user_config_sel), .apll_lock(lock), .sys_div_toggle(div_tog));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // All tasks start and end one nanosecond after a rising edge
  // An idle edge after each access keeps a strobe from retoggling in one step
  task automatic wr(input logic [1:0] i, input logic [15:0] v);
    reg_index = i;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(posedge clk);
    #1 reg_wr = 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic rd_chk(input logic [1:0] i, input logic [15:0] exp);
    reg_index = i;
    reg_rd = 1'b1;
    @(posedge clk);
    #1 reg_rd = 1'b0;
    cmp16({15'h0, reg_rvalid}, 16'h0001);
    cmp16(reg_rdata, exp);
    @(posedge clk);
    #1;
  endtask

  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (5) @(posedge clk);
    #1 sys_rst = 1'b0;
  endtask

  // Startup outcome; 120 cycles cover all three step limits of 20, 50 and 20
  task automatic t_status(input logic [15:0] exp, input logic ring);
    repeat (120) @(posedge clk);
    #1 rd_chk(IDX_STARTUP_STATUS, exp);
    wr(IDX_STARTUP_STATUS, 16'hffff);
    rd_chk(IDX_STARTUP_STATUS, exp);
    rd_chk(2'h3, 16'h0000);
    cmp16({15'h0, ring_osc}, {15'h0, ring});
  endtask

  // Each hold bit reaches only its own block, then all release together
  task automatic t_holds();
    int pos;
    rd_chk(IDX_BLOCK_RESET_HOLDS, BLOCK_RESET_HOLDS_RST);
    wr(IDX_BLOCK_RESET_HOLDS, 16'hffff);
    rd_chk(IDX_BLOCK_RESET_HOLDS, 16'h093f);
    for (int k = 0; k < 7; k++) begin
      pos = (k == 6) ? 8 : k;
      wr(IDX_BLOCK_RESET_HOLDS, 16'h0001 << pos);
      cmp16({9'h0, holds}, 16'h0001 << k);
    end
    wr(IDX_BLOCK_RESET_HOLDS, 16'h0000);
    cmp16({9'h0, holds}, 16'h0000);
  endtask

  // Stop one monitor clock at a time, then all five together, sampled in the high phase
  task automatic t_stops();
    rd_chk(IDX_BLOCK_CLOCK_STOPS, BLOCK_CLOCK_STOPS_RST);
    for (int k = 0; k < 5; k++) begin
      wr(IDX_BLOCK_CLOCK_STOPS, 16'h0002 << k);
      rd_chk(IDX_BLOCK_CLOCK_STOPS, 16'h0002 << k);
      cmp16({10'h0, monitor_clk, digital_clk}, {10'h0, ~(5'h01 << k), 1'b1});
    end
    wr(IDX_BLOCK_CLOCK_STOPS, 16'hf7ff);
    rd_chk(IDX_BLOCK_CLOCK_STOPS, 16'h017f);
    cmp16({10'h0, monitor_clk, digital_clk}, 16'h0001);
    wr(IDX_BLOCK_CLOCK_STOPS, 16'h0000);
    @(posedge clk);
    #1 cmp16({10'h0, monitor_clk, digital_clk}, 16'h003f);
  endtask

  // Digital stop freezes the port; only a reset recovers it
  task automatic t_lock();
    wr(IDX_BLOCK_CLOCK_STOPS, 16'h0800);
    repeat (2) @(posedge clk);
    #1 cmp16({14'h0, reg_port_locked, digital_clk}, 16'h0002);
    wr(IDX_BLOCK_RESET_HOLDS, 16'h0001);
    cmp16({9'h0, holds}, 16'h0000);
    reg_rd = 1'b1;
    @(posedge clk);
    #1 reg_rd = 1'b0;
    cmp16({15'h0, reg_rvalid}, 16'h0000);
  endtask

  task final_report();
    if (miscompares == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Hang guard well above the roughly 330 cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      final_report();
    end
  end

  initial begin
    {sys_rst, reg_wr, reg_rd, quiet, reg_index, reg_wdata} = '0;
    {miscompares, tests_run, cycles} = '0;
    do_reset();
    t_status(16'h000a, 1'b0);
    t_holds();
    t_stops();
    quiet = 1'b1;
    do_reset();
    t_status(16'h00f0, 1'b1);
    quiet = 1'b0;
    do_reset();
    t_lock();
    final_report();
  end
endmodule
`default_nettype wire
